/* rtl/uec_endpoint_ctrl.sv */
// Functional notes
// - Select bit gives shared buffer to EP2/EP1.
// - EP2 IN NAKed when select points EP1.
// - EP1/2 IN NAKed: enable off or done.
// - Force wakeup drives K on lines.
// - Force wakeup never sets bus wakeup flag.
// - Four-bit EP1/2 transmit byte count, reset clears.
// - Writing one clears transmit-first flag.
// - Transmit-first set when tx done at receive.
// - EP1/EP2 answer IN only when enabled or halted.
// - Halt bit makes EP1/EP2 answer STALL.
// - Status shows toggle, SETUP, zero bits.
// - Status holds EP0 receive count, reset-untouched.
// - EP0 buffer reads return received bytes.
// - EP0 buffer writes load transmit buffer.
// - Shared write-only EP1/2 transmit buffer.
// - All sources share one interrupt output.
// - Three end-of-transaction interrupt sources.
// - Completed OUT sets EP0 receive-done flag.
// - EP0 SETUP never stalled, clears EP0 halt.
// - EP1/2 done set on ACK, cleared by one.
// - EP0 receive-done set; then OUT NAKed.
`timescale 1ns/1ps

module uec_endpoint_ctrl
  import uec_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and synchronous reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Token events from the packet engine.
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic [1:0] tok_ep,
  // Answer to each token.
  output logic resp_valid,
  output logic [2:0] resp_code,
  output logic [3:0] resp_len,
  output logic resp_data1,
  // Received data stream for endpoint 0.
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire logic rx_good,
  input wire logic rx_data1,
  // Host handshake after transmitted data, and transmit byte fetch.
  input wire logic tx_ack,
  input wire logic [2:0] tx_idx,
  output logic [7:0] tx_byte,
  // Data line drive for remote wakeup.
  output logic dp_o,
  output logic dp_oe,
  output logic dm_o,
  output logic dm_oe,
  // Shared interrupt request.
  output logic usb_irq
);

  // Refuse an address bus too narrow for the register map.
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // Bus slave state.
  logic aw_hold_r, aw_hold_nxt;
  logic [5:0] aw_idx_r, aw_idx_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [7:0] w_byte_r, w_byte_nxt;
  logic w_lane_r, w_lane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // Control registers written by software.
  logic [7:0] ep0_ctrl_r, ep0_ctrl_nxt;
  logic [7:0] tx_ctrl_r, tx_ctrl_nxt;
  logic [3:0] en_halt_r, en_halt_nxt;
  logic [2:0] irq_en_r, irq_en_nxt;

  // Flags set by the link side.
  logic [2:0] done_r, done_nxt;
  logic tx_first_r, tx_first_nxt;
  logic setup_seen_r, setup_seen_nxt;

  // Link-side transaction state.
  logic resp_valid_r, resp_valid_nxt;
  logic [2:0] resp_code_r, resp_code_nxt;
  logic [3:0] resp_len_r, resp_len_nxt;
  logic resp_data1_r, resp_data1_nxt;
  logic in_pend_r, in_pend_nxt;
  logic in_ep0_r, in_ep0_nxt;
  logic rx_active_r, rx_active_nxt;
  logic irq_r, irq_nxt;
  logic k_drive_r, k_drive_nxt;

  // Storage without reset: buffers, receive count and toggle.
  logic [7:0] ep0_rx_buffer [BUF_BYTES];
  logic [7:0] ep0_tx_buffer [BUF_BYTES];
  logic [7:0] ep12_tx_buffer [BUF_BYTES];
  logic [3:0] rx_fill_r;
  logic [3:0] ep0_rx_byte_count;
  logic ep0_rx_data_toggle;
  logic [7:0] tx_byte_r;

  // Named views of the control fields.
  logic buffer_endpoint_select, ep12_tx_enable, force_wakeup_signal;
  logic [3:0] ep12_tx_byte_count;
  logic ep1_on, ep2_on, ep1_force_halt, ep2_force_halt, ep0_force_halt;
  logic wr_fire, ar_fire, rx_take, rx_finish;
  logic [5:0] ar_idx;
  logic [7:0] rd_byte;

  assign buffer_endpoint_select = tx_ctrl_r[TXC_SELECT_BIT];
  assign ep12_tx_enable = tx_ctrl_r[TXC_ENABLE_BIT];
  assign force_wakeup_signal = tx_ctrl_r[TXC_WAKEUP_BIT];
  assign ep12_tx_byte_count = tx_ctrl_r[3:0];
  assign ep0_force_halt = ep0_ctrl_r[E0C_HALT_BIT];
  assign ep2_on = en_halt_r[3];
  assign ep1_on = en_halt_r[2];
  assign ep2_force_halt = en_halt_r[1];
  assign ep1_force_halt = en_halt_r[0];
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign ar_fire = s_axi_arvalid && arready_r;
  assign ar_idx = s_axi_araddr[7:2];
  assign rx_take = rx_active_r && rx_byte_valid && (rx_fill_r < 4'(BUF_BYTES));
  assign rx_finish = rx_active_r && rx_end && rx_good;

  // Read data mux for the addressed register.
  always_comb begin
    rd_byte = 8'h00;
    if (ar_idx >= IDX_EP0_BUF_FIRST && ar_idx <= IDX_EP0_BUF_LAST) begin
      rd_byte = ep0_rx_buffer[ar_idx[2:0]];
    end else if (ar_idx == IDX_EP0_CONTROL) begin
      rd_byte = ep0_ctrl_r;
    end else if (ar_idx == IDX_EP12_TRANSMIT_CONTROL) begin
      rd_byte = tx_ctrl_r;
    end else if (ar_idx == IDX_EP_ENABLE_STALL_CONTROL) begin
      // The clear bit is write-only and reads back as zero.
      rd_byte = {1'b0, tx_first_r, en_halt_r, 2'b00};
    end else if (ar_idx == IDX_EP_FLAGS) begin
      rd_byte = {2'b00, irq_en_r, done_r};
    end else if (ar_idx == IDX_EP0_RECEIVE_STATUS) begin
      rd_byte = {ep0_rx_data_toggle, setup_seen_r, 2'b00, ep0_rx_byte_count};
    end
  end

  // Bus handshakes: address and data are taken in either order.
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_idx_nxt = aw_idx_r;
    w_hold_nxt = w_hold_r;
    w_byte_nxt = w_byte_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    // Capture the write address while no address is held.
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[7:2];
    end
    // Capture the write data while no data is held.
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    // Complete a write once both halves are in.
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = AXI_OKAY;
      if (!((aw_idx_r >= IDX_EP0_BUF_FIRST && aw_idx_r <= IDX_EP12_BUF_LAST) ||
            (aw_idx_r >= IDX_EP0_CONTROL && aw_idx_r <= IDX_EP_FLAGS) ||
            aw_idx_r == IDX_EP0_RECEIVE_STATUS)) begin
        bresp_nxt = AXI_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Accept one read at a time and answer on the next edge.
    if (ar_fire) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_byte};
      rresp_nxt = AXI_OKAY;
      if (!((ar_idx >= IDX_EP0_BUF_FIRST && ar_idx <= IDX_EP12_BUF_LAST) ||
            (ar_idx >= IDX_EP0_CONTROL && ar_idx <= IDX_EP_FLAGS) ||
            ar_idx == IDX_EP0_RECEIVE_STATUS)) begin
        rresp_nxt = AXI_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // Registers of the bus slave.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_idx_r <= 6'h00;
      w_hold_r <= 1'b0;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= AXI_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_idx_r <= aw_idx_nxt;
      w_hold_r <= w_hold_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Control, flags and token answers; link events win over software clears.
  always_comb begin
    ep0_ctrl_nxt = ep0_ctrl_r;
    tx_ctrl_nxt = tx_ctrl_r;
    en_halt_nxt = en_halt_r;
    irq_en_nxt = irq_en_r;
    done_nxt = done_r;
    tx_first_nxt = tx_first_r;
    setup_seen_nxt = setup_seen_r;
    resp_valid_nxt = 1'b0;
    resp_code_nxt = resp_code_r;
    resp_len_nxt = resp_len_r;
    resp_data1_nxt = resp_data1_r;
    in_pend_nxt = in_pend_r;
    in_ep0_nxt = in_ep0_r;
    rx_active_nxt = rx_active_r;
    // Software writes to the low byte lane.
    if (wr_fire && w_lane_r) begin
      if (aw_idx_r == IDX_EP0_CONTROL) begin
        ep0_ctrl_nxt = w_byte_r;
      end else if (aw_idx_r == IDX_EP12_TRANSMIT_CONTROL) begin
        tx_ctrl_nxt = w_byte_r;
      end else if (aw_idx_r == IDX_EP_ENABLE_STALL_CONTROL) begin
        en_halt_nxt = w_byte_r[ESC_EP2_ON_BIT:ESC_EP1_HALT_BIT];
        if (w_byte_r[ESC_FIRST_CLEAR_BIT]) begin
          tx_first_nxt = 1'b0;
        end
      end else if (aw_idx_r == IDX_EP_FLAGS) begin
        irq_en_nxt = w_byte_r[FLG_IE_SHIFT+2:FLG_IE_SHIFT];
        done_nxt = done_r & ~w_byte_r[2:0];
      end
    end
    // Host acknowledged the data sent for the last accepted IN.
    if (tx_ack && in_pend_r) begin
      in_pend_nxt = 1'b0;
      if (in_ep0_r) begin
        done_nxt[FLG_EP0_TX_DONE] = 1'b1;
      end else begin
        done_nxt[FLG_EP12_TX_DONE] = 1'b1;
      end
    end
    // A good packet finished: flag it and note transmit-first ordering.
    if (rx_finish) begin
      rx_active_nxt = 1'b0;
      done_nxt[FLG_EP0_RX_DONE] = 1'b1;
      if (done_r[FLG_EP0_TX_DONE]) begin
        tx_first_nxt = 1'b1;
      end
    end else if (rx_active_r && rx_end) begin
      rx_active_nxt = 1'b0;
    end
    // Answer a token.
    if (tok_valid) begin
      resp_valid_nxt = 1'b1;
      resp_code_nxt = UEC_RSP_NONE;
      resp_len_nxt = 4'h0;
      in_pend_nxt = 1'b0;
      rx_active_nxt = 1'b0;
      if (tok_ep == 2'h0) begin
        setup_seen_nxt = (tok_pid == UEC_PID_SETUP);
        if (tok_pid == UEC_PID_SETUP) begin
          ep0_ctrl_nxt[E0C_HALT_BIT] = 1'b0;
          resp_code_nxt = UEC_RSP_ACCEPT;
          rx_active_nxt = 1'b1;
        end else if (ep0_force_halt) begin
          resp_code_nxt = UEC_RSP_STALL;
        end else if (tok_pid == UEC_PID_IN) begin
          if (!ep0_ctrl_r[E0C_TX_ENABLE_BIT] || done_r[FLG_EP0_TX_DONE]) begin
            resp_code_nxt = UEC_RSP_NAK;
          end else begin
            resp_code_nxt = UEC_RSP_DATA;
            resp_len_nxt = ep0_ctrl_r[3:0];
            resp_data1_nxt = ep0_ctrl_r[E0C_TOGGLE_BIT];
            in_pend_nxt = 1'b1;
            in_ep0_nxt = 1'b1;
          end
        end else if (tok_pid == UEC_PID_OUT) begin
          if (!ep0_ctrl_r[E0C_RX_ENABLE_BIT] || done_r[FLG_EP0_RX_DONE]) begin
            resp_code_nxt = UEC_RSP_NAK;
          end else begin
            resp_code_nxt = UEC_RSP_ACCEPT;
            rx_active_nxt = 1'b1;
          end
        end
      end else if (tok_ep == 2'h1 || tok_ep == 2'h2) begin
        if ((tok_ep == 2'h1 && ep1_force_halt) || (tok_ep == 2'h2 && ep2_force_halt)) begin
          resp_code_nxt = UEC_RSP_STALL;
        end else if (tok_pid == UEC_PID_IN) begin
          if ((tok_ep == 2'h1 && !ep1_on) || (tok_ep == 2'h2 && !ep2_on)) begin
            resp_code_nxt = UEC_RSP_NONE;
          end else if (!ep12_tx_enable || done_r[FLG_EP12_TX_DONE]) begin
            resp_code_nxt = UEC_RSP_NAK;
          end else if (buffer_endpoint_select != (tok_ep == 2'h2)) begin
            resp_code_nxt = UEC_RSP_NAK;
          end else begin
            resp_code_nxt = UEC_RSP_DATA;
            resp_len_nxt = ep12_tx_byte_count;
            resp_data1_nxt = tx_ctrl_r[TXC_TOGGLE_BIT];
            in_pend_nxt = 1'b1;
            in_ep0_nxt = 1'b0;
          end
        end
      end
    end
  end

  // Interrupt and wakeup drive.
  always_comb begin
    irq_nxt = |(done_nxt & irq_en_nxt);
    k_drive_nxt = tx_ctrl_nxt[TXC_WAKEUP_BIT];
  end

  // Registers of control and link state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep0_ctrl_r <= RST_CONTROL;
      tx_ctrl_r <= RST_CONTROL;
      en_halt_r <= 4'h0;
      irq_en_r <= RST_FLAGS;
      done_r <= RST_FLAGS;
      tx_first_r <= 1'b0;
      setup_seen_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_code_r <= UEC_RSP_NONE;
      resp_len_r <= 4'h0;
      resp_data1_r <= 1'b0;
      in_pend_r <= 1'b0;
      in_ep0_r <= 1'b0;
      rx_active_r <= 1'b0;
      irq_r <= 1'b0;
      k_drive_r <= 1'b0;
    end else begin
      ep0_ctrl_r <= ep0_ctrl_nxt;
      tx_ctrl_r <= tx_ctrl_nxt;
      en_halt_r <= en_halt_nxt;
      irq_en_r <= irq_en_nxt;
      done_r <= done_nxt;
      tx_first_r <= tx_first_nxt;
      setup_seen_r <= setup_seen_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_code_r <= resp_code_nxt;
      resp_len_r <= resp_len_nxt;
      resp_data1_r <= resp_data1_nxt;
      in_pend_r <= in_pend_nxt;
      in_ep0_r <= in_ep0_nxt;
      rx_active_r <= rx_active_nxt;
      irq_r <= irq_nxt;
      k_drive_r <= k_drive_nxt;
    end
  end

  // Buffers and receive bookkeeping keep their contents across reset.
  always_ff @(posedge aclk) begin
    // Software loads the transmit buffers; reads of the shared one give zero.
    if (wr_fire && w_lane_r && aw_idx_r >= IDX_EP0_BUF_FIRST &&
        aw_idx_r <= IDX_EP0_BUF_LAST) begin
      ep0_tx_buffer[aw_idx_r[2:0]] <= w_byte_r;
    end
    if (wr_fire && w_lane_r && aw_idx_r >= IDX_EP12_BUF_FIRST &&
        aw_idx_r <= IDX_EP12_BUF_LAST) begin
      ep12_tx_buffer[aw_idx_r[2:0]] <= w_byte_r;
    end
    // Incoming bytes fill the receive buffer in order.
    if (tok_valid) begin
      rx_fill_r <= 4'h0;
    end else if (rx_take) begin
      ep0_rx_buffer[rx_fill_r[2:0]] <= rx_byte;
      rx_fill_r <= rx_fill_r + 4'h1;
    end
    if (rx_finish) begin
      ep0_rx_byte_count <= rx_fill_r;
      ep0_rx_data_toggle <= rx_data1;
    end
    // Byte fetch for the engine, one edge behind the index.
    tx_byte_r <= in_ep0_r ? ep0_tx_buffer[tx_idx] : ep12_tx_buffer[tx_idx];
  end

  // Port drive.
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign resp_valid = resp_valid_r;
  assign resp_code = resp_code_r;
  assign resp_len = resp_len_r;
  assign resp_data1 = resp_data1_r;
  assign tx_byte = tx_byte_r;
  // Low-speed K state: D+ low, D- high, both driven while waking.
  assign dp_o = 1'b0;
  assign dm_o = k_drive_r;
  assign dp_oe = k_drive_r;
  assign dm_oe = k_drive_r;
  assign usb_irq = irq_r;

endmodule

/* rtl/uec_pkg.sv */
// Shared constants and types of the low-speed endpoint control block.
package uec_pkg;

  // Number of bytes in each endpoint data buffer.
  localparam int unsigned BUF_BYTES = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_EP0_BUF_FIRST = 6'h20;
  localparam logic [5:0] IDX_EP0_BUF_LAST = 6'h27;
  localparam logic [5:0] IDX_EP12_BUF_FIRST = 6'h28;
  localparam logic [5:0] IDX_EP12_BUF_LAST = 6'h2F;
  localparam logic [5:0] IDX_EP0_CONTROL = 6'h38;
  localparam logic [5:0] IDX_EP12_TRANSMIT_CONTROL = 6'h39;
  localparam logic [5:0] IDX_EP_ENABLE_STALL_CONTROL = 6'h3A;
  localparam logic [5:0] IDX_EP_FLAGS = 6'h3B;
  localparam logic [5:0] IDX_EP0_RECEIVE_STATUS = 6'h3D;

  // Field positions of the Endpoint 1/2 transmit control register.
  localparam int unsigned TXC_TOGGLE_BIT = 7;
  localparam int unsigned TXC_SELECT_BIT = 6;
  localparam int unsigned TXC_ENABLE_BIT = 5;
  localparam int unsigned TXC_WAKEUP_BIT = 4;

  // Field positions of the endpoint 0 control register.
  localparam int unsigned E0C_TOGGLE_BIT = 7;
  localparam int unsigned E0C_HALT_BIT = 6;
  localparam int unsigned E0C_TX_ENABLE_BIT = 5;
  localparam int unsigned E0C_RX_ENABLE_BIT = 4;

  // Field positions of the enable and stall control register.
  localparam int unsigned ESC_FIRST_CLEAR_BIT = 7;
  localparam int unsigned ESC_FIRST_FLAG_BIT = 6;
  localparam int unsigned ESC_EP2_ON_BIT = 5;
  localparam int unsigned ESC_EP1_ON_BIT = 4;
  localparam int unsigned ESC_EP2_HALT_BIT = 3;
  localparam int unsigned ESC_EP1_HALT_BIT = 2;

  // Field positions of the flag register: three done flags, three enables.
  localparam int unsigned FLG_EP0_TX_DONE = 0;
  localparam int unsigned FLG_EP0_RX_DONE = 1;
  localparam int unsigned FLG_EP12_TX_DONE = 2;
  localparam int unsigned FLG_IE_SHIFT = 3;

  // Values after reset.
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  // Bus response codes.
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Token kinds delivered by the packet engine.
  typedef enum logic [1:0] {
    UEC_PID_IN = 2'h0,
    UEC_PID_OUT = 2'h1,
    UEC_PID_SETUP = 2'h2
  } uec_pid_t;

  // Answer given to a token.
  typedef enum logic [2:0] {
    UEC_RSP_NONE = 3'h0,
    UEC_RSP_NAK = 3'h1,
    UEC_RSP_STALL = 3'h2,
    UEC_RSP_DATA = 3'h3,
    UEC_RSP_ACCEPT = 3'h4
  } uec_rsp_t;

endpackage

/* sim/uec_host_model.sv */
`timescale 1ns/1ps
// Host side: sends tokens, data bytes and handshakes.
module uec_host_model (
  // Clock.
  input wire logic aclk,
  // Token lines.
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic [1:0] tok_ep,
  // Received data lines.
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end,
  output logic rx_good,
  output logic rx_data1,
  // Handshake and byte fetch.
  output logic tx_ack,
  output logic [2:0] tx_idx
);
  // All lines start idle.
  initial begin
    {tok_valid, tok_pid, tok_ep, rx_byte_valid, rx_byte} = '0;
    {rx_end, rx_good, rx_data1, tx_ack, tx_idx} = '0;
  end

  // One token; the answer stands by the time this returns.
  task automatic token(input logic [1:0] pid, input logic [1:0] ep);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    tok_ep <= ep;
    @(posedge aclk);
    tok_valid <= 1'b0;
    tok_ep <= ~ep;
    repeat (2) @(posedge aclk);
  endtask

  // A data packet of n bytes closed by a good end.
  task automatic packet(input int n, input logic [7:0] b, input logic d1);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= b + i[7:0];
      @(posedge aclk);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    {rx_end, rx_good, rx_data1} <= {2'b11, d1};
    @(posedge aclk);
    {rx_end, rx_good} <= 2'b00;
    @(posedge aclk);
  endtask

  // Acknowledge sent data.
  task automatic ack();
    tx_ack <= 1'b1;
    @(posedge aclk);
    tx_ack <= 1'b0;
    @(posedge aclk);
  endtask

  // Fetch one transmit byte.
  task automatic fetch(input logic [2:0] i);
    tx_idx <= i;
    repeat (2) @(posedge aclk);
  endtask
endmodule

/* sim/uec_endpoint_ctrl_chk.sv */
`timescale 1ns/1ps
// Timing relations at the ports of the endpoint block.
module uec_endpoint_ctrl_chk
  import uec_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Tokens and answers.
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic [1:0] tok_ep,
  input wire logic resp_valid,
  input wire logic [2:0] resp_code,
  // Events and bus reply.
  input wire logic rx_end,
  input wire logic tx_ack,
  input wire logic s_axi_bvalid,
  // Line drive and interrupt.
  input wire logic dp_o,
  input wire logic dp_oe,
  input wire logic dm_o,
  input wire logic dm_oe,
  input wire logic usb_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_resp_follows;
    tok_valid |=> resp_valid;
  endproperty
  a_resp_follows: assert property (p_resp_follows) else $error("no answer");
  property p_resp_cause;
    resp_valid |-> $past(tok_valid);
  endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("stray answer");
  property p_setup;
    tok_valid && tok_pid == UEC_PID_SETUP && tok_ep == 2'h0 |=> resp_code == UEC_RSP_ACCEPT;
  endproperty
  a_setup: assert property (p_setup) else $error("setup refused");
  property p_ep12_out;
    tok_valid && tok_pid == UEC_PID_OUT && tok_ep inside {2'h1, 2'h2}
      |=> resp_code inside {UEC_RSP_NONE, UEC_RSP_STALL};
  endproperty
  a_ep12_out: assert property (p_ep12_out) else $error("bad out answer");
  property p_ep12_in;
    tok_valid && tok_pid == UEC_PID_IN && tok_ep inside {2'h1, 2'h2}
      |=> resp_code != UEC_RSP_ACCEPT;
  endproperty
  a_ep12_in: assert property (p_ep12_in) else $error("bad in answer");
  property p_k_state;
    dp_oe |-> dm_oe && dp_o != dm_o;
  endproperty
  a_k_state: assert property (p_k_state) else $error("not a k state");
  property p_wake_change;
    $changed(dp_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_wake_change: assert property (p_wake_change) else $error("drive moved alone");
  property p_irq_cause;
    $rose(usb_irq) |-> $past(rx_end) || $past(tx_ack) || $rose(s_axi_bvalid);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule

bind uec_endpoint_ctrl uec_endpoint_ctrl_chk u_chk (.*);

/* sim/usb_lowspeed_endpoint_control_tb.sv */
`timescale 1ns/1ps
// Register and token sequences with expected answers.
module usb_lowspeed_endpoint_control_tb
  import uec_pkg::*;
;
  // Bus side driven here.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  // Design outputs.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic resp_valid, resp_data1, dp_o, dp_oe, dm_o, dm_oe, usb_irq;
  logic [2:0] resp_code;
  logic [3:0] resp_len;
  logic [7:0] tx_byte;
  // Host model lines.
  logic tok_valid, rx_byte_valid, rx_end, rx_good, rx_data1, tx_ack;
  logic [1:0] tok_pid, tok_ep;
  logic [7:0] rx_byte;
  logic [2:0] tx_idx;
  int fail_count = 0;
  int cmp_count = 0;

  uec_endpoint_ctrl uut (.*);
  uec_host_model host (.*);

  // Clock of 25 ns.
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // Verdict and end of run.
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One comparison.
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", s, e, g);
      fail_count++;
    end
  endtask

  // Ends the run when a wait ran out.
  task automatic limit(input int n);
    if (n >= 40) begin
      $display("wrong value wait exp done got timeout");
      fail_count++;
      test_done();
    end
  endtask

  // Bus write of one register.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bit a;
    bit w;
    int n;
    {a, w, n} = '0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(a && w && s_axi_bvalid) && n < 40);
    s_axi_bready <= 1'b0;
    limit(n);
    chk("bresp", AXI_OKAY, s_axi_bresp);
    // One idle edge keeps the next call from driving these lines in this step.
    @(posedge aclk);
  endtask

  // Bus read of one register; data checked when OKAY is expected.
  task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
    bit a;
    int n;
    {a, n} = '0;
    s_axi_araddr <= {idx, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) begin
        a = 1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(a && s_axi_rvalid) && n < 40);
    s_axi_rready <= 1'b0;
    limit(n);
    chk("rresp", er, s_axi_rresp);
    if (er == AXI_OKAY) chk($sformatf("reg %h", idx), e, s_axi_rdata);
    // One idle edge keeps the next call from driving these lines in this step.
    @(posedge aclk);
  endtask

  // Token with its expected answer.
  task automatic tk(input logic [1:0] p, input logic [1:0] ep, input logic [2:0] e);
    host.token(p, ep);
    chk("answer", e, resp_code);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_EP12_TRANSMIT_CONTROL, 8'h00, AXI_OKAY);
    rd(IDX_EP_ENABLE_STALL_CONTROL, 8'h00, AXI_OKAY);
    rd(6'h00, 8'h00, AXI_SLVERR);
    tk(UEC_PID_IN, 2'h1, UEC_RSP_NONE);
    wr(IDX_EP_ENABLE_STALL_CONTROL, 8'h30);
    tk(UEC_PID_IN, 2'h1, UEC_RSP_NAK);
    wr(IDX_EP12_TRANSMIT_CONTROL, 8'h25);
    tk(UEC_PID_IN, 2'h2, UEC_RSP_NAK);
    tk(UEC_PID_IN, 2'h1, UEC_RSP_DATA);
    chk("len", 32'h5, resp_len);
    chk("data1", 1'b0, resp_data1);
    for (int i = 0; i < 8; i++) wr(IDX_EP12_BUF_FIRST + i[5:0], 8'hA0 + i[7:0]);
    for (int i = 0; i < 8; i++) begin
      host.fetch(i[2:0]);
      chk("tx", 8'hA0 + i[7:0], tx_byte);
    end
    rd(IDX_EP12_BUF_LAST, 8'h00, AXI_OKAY);
    host.ack();
    rd(IDX_EP_FLAGS, 8'h04, AXI_OKAY);
    tk(UEC_PID_IN, 2'h1, UEC_RSP_NAK);
    wr(IDX_EP_FLAGS, 8'h04);
    rd(IDX_EP_FLAGS, 8'h00, AXI_OKAY);
    wr(IDX_EP12_TRANSMIT_CONTROL, 8'hE5);
    tk(UEC_PID_IN, 2'h2, UEC_RSP_DATA);
    chk("data1", 1'b1, resp_data1);
    tk(UEC_PID_IN, 2'h1, UEC_RSP_NAK);
    wr(IDX_EP_ENABLE_STALL_CONTROL, 8'h3C);
    for (int p = 0; p < 2; p++) begin
      for (int e = 1; e < 3; e++) tk(p[1:0], e[1:0], UEC_RSP_STALL);
    end
    wr(IDX_EP_ENABLE_STALL_CONTROL, 8'h30);
    wr(IDX_EP_FLAGS, 8'h38);
    wr(IDX_EP12_TRANSMIT_CONTROL, 8'h10);
    chk("drive", 2'b11, {dp_oe, dm_oe});
    chk("kstate", 1'b1, dp_o ^ dm_o);
    chk("irq", 1'b0, usb_irq);
    wr(IDX_EP12_TRANSMIT_CONTROL, 8'h00);
    chk("drive", 2'b00, {dp_oe, dm_oe});
    wr(IDX_EP0_CONTROL, 8'h50);
    tk(UEC_PID_OUT, 2'h0, UEC_RSP_STALL);
    tk(UEC_PID_SETUP, 2'h0, UEC_RSP_ACCEPT);
    rd(IDX_EP0_CONTROL, 8'h10, AXI_OKAY);
    host.packet(3, 8'h50, 1'b1);
    rd(IDX_EP0_RECEIVE_STATUS, 8'hC3, AXI_OKAY);
    for (int i = 0; i < 3; i++) rd(IDX_EP0_BUF_FIRST + i[5:0], 8'h50 + i[7:0], AXI_OKAY);
    chk("irq", 1'b1, usb_irq);
    rd(IDX_EP_FLAGS, 8'h3A, AXI_OKAY);
    tk(UEC_PID_OUT, 2'h0, UEC_RSP_NAK);
    wr(IDX_EP0_BUF_FIRST, 8'h5A);
    wr(IDX_EP0_CONTROL, 8'h31);
    tk(UEC_PID_IN, 2'h0, UEC_RSP_DATA);
    host.fetch(3'h0);
    chk("tx0", 8'h5A, tx_byte);
    host.ack();
    wr(IDX_EP_FLAGS, 8'h3A);
    tk(UEC_PID_OUT, 2'h0, UEC_RSP_ACCEPT);
    host.packet(2, 8'h60, 1'b0);
    rd(IDX_EP_ENABLE_STALL_CONTROL, 8'h70, AXI_OKAY);
    rd(IDX_EP0_RECEIVE_STATUS, 8'h02, AXI_OKAY);
    wr(IDX_EP_ENABLE_STALL_CONTROL, 8'h30);
    rd(IDX_EP_ENABLE_STALL_CONTROL, 8'h70, AXI_OKAY);
    wr(IDX_EP_ENABLE_STALL_CONTROL, 8'hB0);
    rd(IDX_EP_ENABLE_STALL_CONTROL, 8'h30, AXI_OKAY);
    test_done();
  end
endmodule
